// [core/vrt_ctrl.sv]
// Purpose: Host controller sequencing transfer and serial cycles of a video RAM
// Assumes: Software issues one command at a time through AXI4-Lite registers
// Notes:   Illegal orderings are refused and flagged instead of reaching the pins
`timescale 1ns/10ps
module vrt_ctrl #(
   parameter int unsigned AW = 8
) (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [AW-1:0]       s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [AW-1:0]       s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output vrt_pkg::vrt_pins_t       pins,
   input  wire logic [3:0]          sio_i,
   output logic [3:0]               sio_o,
   output logic                     sio_oe_n,
   input  wire logic                half_indicator_out
);

   typedef enum logic [3:0] {
      S_IDLE, S_SETUP, S_RAS, S_CAS, S_TOE, S_END, S_SC_LO, S_SC_HI, S_SC_TAIL
   } vrt_state_t;

   vrt_state_t         st_q;
   vrt_pkg::vrt_pins_t pins_q;
   logic [7:0]         cnt_q;
   logic [7:0]         sc_gap_q;
   logic [7:0]         ras_gap_q;
   logic [2:0]         cmd_q;
   logic [8:0]         row_q;
   logic [8:0]         col_q;
   logic [3:0]         tx_q;
   logic [3:0]         rx_q;
   logic               dir_out_q;
   logic               start_set_q;
   logic               src_valid_q;
   logic               src_msb_q;
   logic               err_q;
   logic [3:0]         sio_s1_q;
   logic [3:0]         sio_s2_q;
   logic               half_s1_q;
   logic               half_s2_q;
   logic               bvalid_q;
   logic [1:0]         bresp_q;
   logic               rvalid_q;
   logic [1:0]         rresp_q;
   logic [31:0]        rdata_q;
   logic               wr_go;
   logic               cmd_wr;
   logic               go;
   logic [2:0]         new_cmd;
   logic               phase_done;

   ////////////////////////////////////////////////////////////////////////////////
   // Ordering checks on the host side

   function automatic logic cmd_legal(input logic [2:0] c, input logic [8:0] row,
                                      input logic dir_out, input logic start_set,
                                      input logic src_valid, input logic src_msb);
      logic msb_ok;
      msb_ok = !src_valid || (row[8] == src_msb);
      case (c)
         vrt_pkg::CMD_READ_XFER:   return 1'b1;
         vrt_pkg::CMD_PSEUDO:      return 1'b1;
         vrt_pkg::CMD_WRITE_XFER:  return msb_ok;
         vrt_pkg::CMD_SPLIT_READ:  return start_set && dir_out;
         vrt_pkg::CMD_SPLIT_WRITE: return start_set && !dir_out && msb_ok;
         vrt_pkg::CMD_SER_READ:    return start_set && dir_out;
         vrt_pkg::CMD_SER_WRITE:   return start_set && !dir_out;
         default:                  return 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave; address and data are taken together

   assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;
   assign cmd_wr  = wr_go && s_axi_awaddr[7:0] == vrt_pkg::REG_CMD && s_axi_wstrb[0];
   assign new_cmd = s_axi_wdata[2:0];
   assign go      = cmd_wr && st_q == S_IDLE &&
                    cmd_legal(new_cmd, row_q, dir_out_q, start_set_q, src_valid_q, src_msb_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= vrt_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         case (s_axi_awaddr[7:0])
            vrt_pkg::REG_CMD, vrt_pkg::REG_ROW, vrt_pkg::REG_COL,
            vrt_pkg::REG_SDATA, vrt_pkg::REG_STATUS: bresp_q <= vrt_pkg::RESP_OKAY;
            default:                                 bresp_q <= vrt_pkg::RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         row_q <= 9'h000;
         col_q <= 9'h000;
         tx_q  <= 4'h0;
      end else if (wr_go) begin
         if (s_axi_awaddr[7:0] == vrt_pkg::REG_ROW) begin
            if (s_axi_wstrb[0]) row_q[7:0] <= s_axi_wdata[7:0];
            if (s_axi_wstrb[1]) row_q[8]   <= s_axi_wdata[8];
         end
         if (s_axi_awaddr[7:0] == vrt_pkg::REG_COL) begin
            if (s_axi_wstrb[0]) col_q[7:0] <= s_axi_wdata[7:0];
            if (s_axi_wstrb[1]) col_q[8]   <= s_axi_wdata[8];
         end
         if (s_axi_awaddr[7:0] == vrt_pkg::REG_SDATA && s_axi_wstrb[0]) tx_q <= s_axi_wdata[3:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rresp_q  <= vrt_pkg::RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rresp_q  <= vrt_pkg::RESP_OKAY;
         case (s_axi_araddr[7:0])
            vrt_pkg::REG_CMD:    rdata_q <= {29'h0, cmd_q};
            vrt_pkg::REG_ROW:    rdata_q <= {23'h0, row_q};
            vrt_pkg::REG_COL:    rdata_q <= {23'h0, col_q};
            vrt_pkg::REG_SDATA:  rdata_q <= {28'h0, rx_q};
            vrt_pkg::REG_STATUS: rdata_q <= {26'h0, src_valid_q, err_q, half_s2_q,
                                             start_set_q, dir_out_q, st_q != S_IDLE};
            default: begin
               rdata_q <= 32'h0000_0000;
               rresp_q <= vrt_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sio_s1_q  <= 4'h0;
         sio_s2_q  <= 4'h0;
         half_s1_q <= 1'b0;
         half_s2_q <= 1'b0;
      end else begin
         sio_s1_q  <= sio_i;
         sio_s2_q  <= sio_s1_q;
         half_s1_q <= half_indicator_out;
         half_s2_q <= half_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Device state as the host tracks it

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_q       <= vrt_pkg::CMD_READ_XFER;
         dir_out_q   <= 1'b0;
         start_set_q <= 1'b0;
         src_valid_q <= 1'b0;
         src_msb_q   <= 1'b0;
         err_q       <= 1'b0;
      end else if (cmd_wr) begin
         err_q <= !go;
         if (go) begin
            cmd_q <= new_cmd;
            case (new_cmd)
               vrt_pkg::CMD_READ_XFER: begin
                  dir_out_q   <= 1'b1;
                  start_set_q <= 1'b1;
                  src_valid_q <= 1'b1;
                  src_msb_q   <= row_q[8];
               end
               vrt_pkg::CMD_SPLIT_READ: begin
                  src_valid_q <= 1'b1;
                  src_msb_q   <= row_q[8];
               end
               vrt_pkg::CMD_PSEUDO: begin
                  dir_out_q   <= 1'b0;
                  start_set_q <= 1'b1;
               end
               vrt_pkg::CMD_WRITE_XFER: dir_out_q <= 1'b0;
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Strobe sequencer; each phase lasts PHASE_CYC cycles, except S_END (SRD_CYC) and S_SETUP, which also waits for the serial gap

   assign phase_done = cnt_q >= vrt_pkg::PHASE_CYC - 8'h01;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q   <= S_IDLE;
         cnt_q  <= 8'h00;
         pins_q <= vrt_pkg::PINS_IDLE;
         rx_q   <= 4'h0;
      end else begin
         cnt_q <= cnt_q + 8'h01;
         case (st_q)
            S_IDLE: begin
               cnt_q <= 8'h00;
               if (go) begin
                  if (new_cmd == vrt_pkg::CMD_SER_READ || new_cmd == vrt_pkg::CMD_SER_WRITE) begin
                     st_q <= S_SC_LO;
                  end else begin
                     st_q <= S_SETUP;
                     pins_q.addr <= row_q;
                     pins_q.transfer_output_enable_n <= 1'b0;
                     pins_q.we_n <= new_cmd == vrt_pkg::CMD_READ_XFER ||
                                    new_cmd == vrt_pkg::CMD_SPLIT_READ;
                     pins_q.special_function_select <= new_cmd == vrt_pkg::CMD_SPLIT_READ ||
                                                       new_cmd == vrt_pkg::CMD_SPLIT_WRITE;
                     pins_q.serial_enable_n <= new_cmd == vrt_pkg::CMD_PSEUDO;
                  end
               end
            end
            // Split cycles run beside serial clocking, so honour the gap here
            S_SETUP: if (phase_done && sc_gap_q >= vrt_pkg::STS_CYC) begin
               st_q         <= S_RAS;
               cnt_q        <= 8'h00;
               pins_q.ras_n <= 1'b0;
            end
            S_RAS: if (phase_done) begin
               st_q         <= S_CAS;
               cnt_q        <= 8'h00;
               pins_q.addr  <= col_q;
               pins_q.cas_n <= 1'b0;
            end
            S_CAS: if (phase_done) begin
               cnt_q <= 8'h00;
               pins_q.transfer_output_enable_n <= 1'b1;
               st_q <= cmd_q == vrt_pkg::CMD_READ_XFER ? S_TOE : S_END;
               if (cmd_q != vrt_pkg::CMD_READ_XFER) begin
                  pins_q.ras_n <= 1'b1;
                  pins_q.cas_n <= 1'b1;
               end
            end
            S_TOE: if (phase_done) begin
               st_q         <= S_END;
               cnt_q        <= 8'h00;
               pins_q.ras_n <= 1'b1;
               pins_q.cas_n <= 1'b1;
            end
            // Recovery after the row strobe rises before any serial access
            S_END: if (cnt_q >= vrt_pkg::SRD_CYC - 8'h01) begin
               st_q <= S_IDLE;
               pins_q.serial_enable_n <= 1'b0;
               pins_q.we_n <= 1'b1;
               pins_q.special_function_select <= 1'b0;
            end
            S_SC_LO: if (phase_done) begin
               st_q                <= S_SC_HI;
               cnt_q               <= 8'h00;
               pins_q.serial_clock <= 1'b1;
            end
            S_SC_HI: if (phase_done) begin
               st_q                <= S_SC_TAIL;
               cnt_q               <= 8'h00;
               pins_q.serial_clock <= 1'b0;
               if (cmd_q == vrt_pkg::CMD_SER_READ) rx_q <= sio_s2_q;
            end
            S_SC_TAIL: if (phase_done) st_q <= S_IDLE;
            default: st_q <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Gap counters since the last serial clock rise and row strobe rise

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sc_gap_q  <= 8'hFF;
         ras_gap_q <= 8'hFF;
      end else begin
         if (st_q == S_SC_LO && phase_done) sc_gap_q <= 8'h00;
         else if (sc_gap_q != 8'hFF) sc_gap_q <= sc_gap_q + 8'h01;
         if (!pins_q.ras_n) ras_gap_q <= 8'h00;
         else if (ras_gap_q != 8'hFF) ras_gap_q <= ras_gap_q + 8'h01;
      end
   end

   assign pins = pins_q;

   // Host drives data only in write mode; pins stay released in read mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sio_o    <= 4'h0;
         sio_oe_n <= 1'b1;
      end else begin
         sio_o    <= tx_q;
         sio_oe_n <= dir_out_q || !(cmd_q == vrt_pkg::CMD_SER_WRITE &&
                     (st_q == S_SC_LO || st_q == S_SC_HI));
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   property p_xfer_decode;
      @(posedge aclk) disable iff (!aresetn)
      $fell(pins_q.ras_n) |-> pins_q.cas_n && !pins_q.transfer_output_enable_n;
   endproperty
   a_xfer_decode: assert property (p_xfer_decode) else $error("bad transfer decode");

   property p_toe_rise;
      @(posedge aclk) disable iff (!aresetn)
      st_q == S_CAS && phase_done && cmd_q == vrt_pkg::CMD_READ_XFER
      |=> $rose(pins_q.transfer_output_enable_n) && !pins_q.ras_n;
   endproperty
   a_toe_rise: assert property (p_toe_rise) else $error("no enable rise");

   property p_sc_ras;
      @(posedge aclk) disable iff (!aresetn)
      !pins_q.ras_n |-> !pins_q.serial_clock;
   endproperty
   a_sc_ras: assert property (p_sc_ras) else $error("clock during row low");

   property p_srd;
      @(posedge aclk) disable iff (!aresetn)
      $rose(pins_q.serial_clock) |-> ras_gap_q >= vrt_pkg::SRD_CYC;
   endproperty
   a_srd: assert property (p_srd) else $error("serial access too soon");

   property p_sts;
      @(posedge aclk) disable iff (!aresetn)
      $fell(pins_q.ras_n) |-> sc_gap_q > vrt_pkg::STS_CYC;
   endproperty
   a_sts: assert property (p_sts) else $error("clock to row fall gap");

   property p_release;
      @(posedge aclk) disable iff (!aresetn)
      dir_out_q && st_q != S_IDLE |-> sio_oe_n;
   endproperty
   a_release: assert property (p_release) else $error("driving in read mode");

   property p_split_read;
      @(posedge aclk) disable iff (!aresetn)
      $fell(pins_q.ras_n) && pins_q.we_n && pins_q.special_function_select |-> dir_out_q;
   endproperty
   a_split_read: assert property (p_split_read) else $error("split read in input");

   property p_split_write;
      @(posedge aclk) disable iff (!aresetn)
      go && new_cmd == vrt_pkg::CMD_SPLIT_WRITE |=> !dir_out_q && st_q == S_SETUP;
   endproperty
   a_split_write: assert property (p_split_write) else $error("split write in output");

   property p_msb;
      @(posedge aclk) disable iff (!aresetn)
      $fell(pins_q.ras_n) && !pins_q.we_n && !pins_q.serial_enable_n && src_valid_q
      |-> pins_q.addr[8] == src_msb_q;
   endproperty
   a_msb: assert property (p_msb) else $error("row msb mismatch");

   property p_start;
      @(posedge aclk) disable iff (!aresetn)
      $rose(pins_q.serial_clock) |-> start_set_q;
   endproperty
   a_start: assert property (p_start) else $error("serial before start set");

endmodule

// [dv/vrt_ctrl_tb.sv]
// Purpose: Self-checking bench for the video RAM transfer controller
// Assumes: Behavioural device on the pins, AXI4-Lite master tasks
// Notes:   Serial words move one command at a time, so runs are slow
`timescale 1ns/10ps
module vrt_ctrl_tb;
   logic               aclk, aresetn, awvalid, wvalid, bvalid, arvalid, rvalid;
   logic               awready, wready, arready, sio_oe_n, dev_oe_n, half;
   logic [7:0]         awaddr, araddr;
   logic [31:0]        wdata, rdata, v;
   logic [1:0]         bresp, rresp, resp;
   logic [3:0]         sio_i, sio_o, dev_data;
   vrt_pkg::vrt_pins_t pins;
   int                 n_fail, checked;
   ////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // A released line shows the inverse, never a stale value
   assign sio_i = !sio_oe_n ? sio_o : !dev_oe_n ? dev_data : ~dev_data;
   vrt_ctrl u_vrt_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(1'b1), .pins(pins), .sio_i(sio_i), .sio_o(sio_o),
      .sio_oe_n(sio_oe_n), .half_indicator_out(half));
   vrt_dev_model u_vrt_dev_model (.pins(pins), .sio_line(sio_i), .host_oe_n(sio_oe_n),
      .dev_data(dev_data), .dev_oe_n(dev_oe_n), .half_indicator_out(half));
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", s, e, g);
         n_fail++;
      end
   endtask
   // Selects 0 awready, 1 bvalid, 2 arready, 3 rvalid
   task automatic await(input int w);
      logic f;
      int   k;
      k = 0;
      do begin
         @(posedge aclk);
         k++;
         f = w == 0 ? awready : w == 1 ? bvalid : w == 2 ? arready : rvalid;
      end while (f !== 1'b1 && k < 300);
      if (f !== 1'b1) begin
         $display("ERROR handshake expected 1 seen %b", f);
         n_fail++;
         test_done();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
      await(0);
      {awvalid, wvalid} <= 2'b00;
      await(1);
      resp = bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      {araddr, arvalid} <= {a, 1'b1};
      await(2);
      arvalid <= 1'b0;
      await(3);
      {v, resp} = {rdata, rresp};
   endtask
   task automatic cmd(input logic [2:0] c, input logic [8:0] r, input logic [8:0] col);
      wr(vrt_pkg::REG_ROW, 32'(r));
      wr(vrt_pkg::REG_COL, 32'(col));
      wr(vrt_pkg::REG_CMD, 32'(c));
      for (int k = 0; k < 40 && (k == 0 || v[vrt_pkg::ST_BUSY] !== 1'b0); k++)
         rd(vrt_pkg::REG_STATUS);
      if (v[vrt_pkg::ST_BUSY] !== 1'b0) begin
         $display("ERROR busy expected 0 seen %b", v[vrt_pkg::ST_BUSY]);
         n_fail++;
         test_done();
      end
   endtask
   task automatic st(input logic [5:0] e, input string s);
      rd(vrt_pkg::REG_STATUS);
      chk(s, 32'(e), 32'(v[5:0]));
   endtask
   task automatic sread(input logic [3:0] e, input string s);
      cmd(vrt_pkg::CMD_SER_READ, 9'h000, 9'h000);
      rd(vrt_pkg::REG_SDATA);
      chk(s, 32'(e), 32'(v[3:0]));
   endtask
   function automatic logic [3:0] pat(input int r, input int c);
      return 4'(r + c + (c >> 5));
   endfunction
   initial begin
      {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
      n_fail = 0;
      checked = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      chk("pins idle", 32'(vrt_pkg::PINS_IDLE), 32'(pins));
      st(6'h00, "status reset");
      rd(8'h14);
      chk("unmapped read", {30'h0, vrt_pkg::RESP_SLVERR}, {v[29:0], resp});
      wr(8'h14, 32'h0000_0000);
      chk("unmapped write", 32'(vrt_pkg::RESP_SLVERR), 32'(resp));
      cmd(vrt_pkg::CMD_SER_READ, 9'h000, 9'h000);
      st(6'h10, "serial unstarted");
      cmd(vrt_pkg::CMD_SPLIT_READ, 9'h000, 9'h000);
      st(6'h10, "split unstarted");
      $display("test registers done");
      cmd(vrt_pkg::CMD_READ_XFER, 9'h005, 9'h0FE);
      st(6'h26, "read xfer");
      sread(pat(5, 'hFE), "word 0FE");
      sread(pat(5, 'hFF), "word 0FF");
      st(6'h2E, "half after 255");
      sread(pat(5, 'h100), "word 100");
      $display("test read transfer done");
      cmd(vrt_pkg::CMD_SPLIT_READ, 9'h107, 9'h010);
      st(6'h2E, "split read");
      for (int k = 0; k < 255; k++) cmd(vrt_pkg::CMD_SER_READ, 9'h000, 9'h000);
      st(6'h26, "half after 511");
      sread(pat('h107, 'h010), "split start");
      $display("test split read done");
      cmd(vrt_pkg::CMD_WRITE_XFER, 9'h020, 9'h000);
      st(6'h36, "msb mismatch");
      cmd(vrt_pkg::CMD_SPLIT_WRITE, 9'h120, 9'h000);
      st(6'h36, "split write out");
      cmd(vrt_pkg::CMD_PSEUDO, 9'h000, 9'h1FE);
      st(6'h2C, "pseudo");
      for (int k = 0; k < 4; k++) begin
         wr(vrt_pkg::REG_SDATA, 32'(k + 10));
         cmd(vrt_pkg::CMD_SER_WRITE, 9'h000, 9'h000);
      end
      cmd(vrt_pkg::CMD_WRITE_XFER, 9'h130, 9'h1FE);
      st(6'h2C, "write xfer");
      cmd(vrt_pkg::CMD_SPLIT_WRITE, 9'h140, 9'h000);
      st(6'h2C, "split write");
      cmd(vrt_pkg::CMD_READ_XFER, 9'h130, 9'h1FE);
      st(6'h2E, "read back");
      sread(4'hA, "back 1FE");
      sread(4'hB, "back 1FF");
      sread(4'hC, "back 000");
      cmd(vrt_pkg::CMD_READ_XFER, 9'h140, 9'h001);
      sread(4'hD, "split back");
      chk("device breaches", 32'h0, 32'(u_vrt_dev_model.viol));
      $display("test write back done");
      test_done();
   end
endmodule

// [dv/vrt_dev_model.sv]
// Purpose: Behavioural video RAM transfer and serial port
// Assumes: Pins come from flip-flops, so their edges are clean
// Notes:   Controller-side breaches are counted in viol, not stopped
`timescale 1ns/10ps
module vrt_dev_model #(
   parameter realtime T_STS = 20.0,
   parameter realtime T_SRD = 30.0
) (
   input  wire vrt_pkg::vrt_pins_t pins,
   input  wire logic [3:0]         sio_line,
   input  wire logic               host_oe_n,
   output logic [3:0]              dev_data,
   output logic                    dev_oe_n,
   output logic                    half_indicator_out
);
   logic [3:0] mem [0:511][0:511];
   logic [3:0] serial_access_register [0:511];
   logic [8:0] ptr, row, col, nxt;
   logic [2:0] kind;
   logic       xfer, dir_out, pend, started, src_msb;
   realtime    t_sc, t_ras;
   int         viol;
   initial begin
      for (int r = 0; r < 512; r++)
         for (int c = 0; c < 512; c++)
            mem[r][c] = 4'(r + c + (c >> 5));
      {ptr, nxt, xfer, dir_out, pend, started, src_msb, dev_data, dev_oe_n} = 28'h1;
      viol = 0;
      t_sc = 0;
      t_ras = 0;
   end
   assign half_indicator_out = ptr[8];
   always @(negedge pins.ras_n) begin
      xfer = pins.cas_n && !pins.transfer_output_enable_n;
      kind = {pins.we_n, pins.special_function_select, pins.serial_enable_n};
      row = pins.addr;
      if ($realtime - t_sc < T_STS || xfer && kind[1] && !started) viol++;
   end
   always @(negedge pins.cas_n) if (xfer) col = pins.addr;
   always @(negedge host_oe_n) if (!dev_oe_n) viol++;
   // Row moves on the enable rise, so a late rise loses the transfer
   always @(posedge pins.transfer_output_enable_n) if (xfer && kind[2:1] == 2'b10) begin
      for (int c = 0; c < 512; c++) serial_access_register[c] = mem[row][c];
      {ptr, dir_out, started, pend, src_msb, xfer} = {col, 3'b110, row[8], 1'b0};
   end
   always @(posedge pins.ras_n) if (xfer) begin
      t_ras = $realtime;
      nxt = {~ptr[8], col[7:0]};
      for (int c = 0; c < 512; c++) begin
         if (kind[2:1] == 2'b11 && c[8] == nxt[8]) serial_access_register[c] = mem[row][c];
         if (kind == 3'b000 || kind[2:1] == 2'b01 && c[8] == nxt[8]) mem[row][c] = serial_access_register[c];
      end
      if (kind[2:1] == 2'b11) {pend, src_msb} = {1'b1, row[8]};
      if (kind[2:1] == 2'b10 || kind[1] && kind[2] != dir_out) viol++;
      if (!kind[2] && (kind[1] || !kind[0]) && row[8] != src_msb) viol++;
      if (kind[2:1] == 2'b01) pend = 1'b1;
      if (kind[2:1] == 2'b00) {ptr, dir_out, started, pend, dev_oe_n} = {col, 4'b0101};
      xfer = 1'b0;
   end
   always @(posedge pins.serial_clock) begin
      if (!started || xfer && kind[2:1] == 2'b00) viol++;
      if (!dir_out && $realtime - t_ras < T_SRD) viol++;
      t_sc = $realtime;
      if (dir_out) {dev_data, dev_oe_n} = {serial_access_register[ptr], pins.serial_enable_n};
      if (dir_out && !host_oe_n) viol++;
      if (!dir_out && !pins.serial_enable_n) serial_access_register[ptr] = sio_line;
      if (ptr[7:0] == 8'hFF && pend) {ptr, pend} = {nxt, 1'b0};
      else ptr = ptr + 9'h001;
   end
endmodule

// [inc/vrt_pkg.sv]
// Purpose: Constants and types for the video RAM row-transfer and serial port controller
// Assumes: 100 MHz aclk, AXI4-Lite register access, device pins driven from flip-flops
// Notes:   Times are nanoseconds; cycle counts derive from them and round up
package vrt_pkg;

   localparam int unsigned CLK_NS     = 10;
   localparam int unsigned T_PHASE_NS = 40;
   localparam int unsigned T_SRD_NS   = 30;
   localparam int unsigned T_STS_NS   = 20;

   function automatic logic [7:0] cyc(input int unsigned ns);
      return 8'((ns + CLK_NS - 1) / CLK_NS);
   endfunction

   localparam logic [7:0] PHASE_CYC = cyc(T_PHASE_NS);
   localparam logic [7:0] SRD_CYC   = cyc(T_SRD_NS);
   localparam logic [7:0] STS_CYC   = cyc(T_STS_NS);

   localparam logic [7:0] REG_CMD    = 8'h00;
   localparam logic [7:0] REG_ROW    = 8'h04;
   localparam logic [7:0] REG_COL    = 8'h08;
   localparam logic [7:0] REG_SDATA  = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;

   localparam int unsigned ST_BUSY  = 0;
   localparam int unsigned ST_DIR   = 1;
   localparam int unsigned ST_START = 2;
   localparam int unsigned ST_HALF  = 3;
   localparam int unsigned ST_ERR   = 4;
   localparam int unsigned ST_SRC   = 5;

   localparam logic [2:0] CMD_READ_XFER   = 3'h0;
   localparam logic [2:0] CMD_SPLIT_READ  = 3'h1;
   localparam logic [2:0] CMD_PSEUDO      = 3'h2;
   localparam logic [2:0] CMD_WRITE_XFER  = 3'h3;
   localparam logic [2:0] CMD_SPLIT_WRITE = 3'h4;
   localparam logic [2:0] CMD_SER_READ    = 3'h5;
   localparam logic [2:0] CMD_SER_WRITE   = 3'h6;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic       ras_n;
      logic       cas_n;
      logic       we_n;
      logic       transfer_output_enable_n;
      logic       special_function_select;
      logic       serial_enable_n;
      logic       serial_clock;
      logic [8:0] addr;
   } vrt_pins_t;

   localparam vrt_pins_t PINS_IDLE = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
      transfer_output_enable_n: 1'b1, special_function_select: 1'b0,
      serial_enable_n: 1'b0, serial_clock: 1'b0, addr: 9'h000};

endpackage
